// *** core/uhp_pkg.sv ***
// Constants and types for the hub port status logic.
// Assumes a 100 MHz device clock and an APB register bus.
//
// What this block does
// R01: One upstream port and four downstream ports.
// R02: Packet engine handles low-level USB protocol work.
// R03: Firmware handles setup, FIFOs, suspend and toggles.
// R04: Two device addresses, hub and compound function.
// R05: Both lines low means nothing connected.
// R06: Low speed attach sets connect, raises interrupt only while line control is zero.
// R07: Full speed attach sets connect, clears speed.
// R08: Firmware programs port speed after connect.
// R09: Connect recorded after non-SE0 over 2.5 us.
// R10: Disconnect after SE0 of 2.0 to 2.5 us.
// R11: Connect status bits 0..3 are ports 1..4.
// R12: Connect status cleared by reset and bus reset.
// R13: Upper four connect status bits read zero.
// R14: Hub drives end-of-packet at EOF1 point.
// R15: Upstream control register layout, cleared on reset.
// R16: Nonzero line control forces upstream port manually.
// R17: Line control codes select forced line levels.
// R18: Bus activity sticky; write 0 clears it.
// R19: Upstream line status bits follow the pins.
// R20: Upstream SE0 of 12 to 16 us is bus reset.
// R21: Hub interrupt held until acknowledged, re-raised.
// R22: Per-port counter filters line state glitches.
package uhp_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CONN_NS = 2500;
  localparam int DISC_MIN_NS = 2000;
  localparam int RST_MIN_US = 12;
  localparam int RST_MAX_US = 16;
  // Connect: strictly more than 2.5 us, so one cycle past the count
  localparam int CONN_CYC = (CONN_NS * CLK_MHZ + 999) / 1000 + 1;
  // Disconnect at 2.0 us, within the 2.0 to 2.5 us window
  localparam int DISC_CYC = (DISC_MIN_NS * CLK_MHZ + 999) / 1000;
  // Bus reset inside the 12..16 us window, taken at 14 us
  localparam int BRST_CYC = (RST_MIN_US + RST_MAX_US) / 2 * CLK_MHZ;
  localparam int FLT_W = 9;
  localparam int BRST_W = 11;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int NPORT = 4;
  localparam logic [11:0] UPSTREAM_IDX = 12'h01f;
  localparam logic [11:0] CONNECT_IDX = 12'h048;
  localparam logic [11:0] SPEED_IDX = 12'h04a;
  localparam logic [11:0] ADDR_HUB_IDX = 12'h010;
  localparam logic [11:0] ADDR_FN_IDX = 12'h040;
  localparam logic [11:0] IRQ_IDX = 12'h060;
  localparam logic [7:0] UPSTREAM_RST = 8'h00;
  localparam logic [7:0] CONNECT_RST = 8'h00;
  localparam logic [7:0] SPEED_RST = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam int ACT_BIT = 3;
  localparam int DM_BIT = 4;
  localparam int DP_BIT = 5;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LC_ENGINE, LC_J, LC_K, LC_SE0, LC_LOW, LC_DPZ_DMLOW,
    LC_DPLOW_DMZ, LC_BOTHZ
  } uhp_linectl_t;

  typedef struct packed {
    logic dp;
    logic dm;
  } uhp_pair_t;

  typedef struct packed {
    logic dp_o;
    logic dp_oe;
    logic dm_o;
    logic dm_oe;
  } uhp_drive_t;

  function automatic logic [11:0] uhp_index(input logic [13:0] a);
    uhp_index = a[13:2];
  endfunction : uhp_index

endpackage : uhp_pkg

// *** core/uhp_port_det.sv ***
// Connect and disconnect detector for one downstream port.
// Assumes line inputs already synchronised to i_clk.
`timescale 1ns/100ps
module uhp_port_det
  import uhp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clear,
  // Synchronised line state
  input wire uhp_pair_t i_line,
  // Detector results
  output logic o_conn,
  output logic o_low_speed,
  output logic o_change
);

  logic se0;
  logic [FLT_W-1:0] cnt;
  logic next_conn;

  assign se0 = !i_line.dp && !i_line.dm; // see R05

  // ---------------------------------------------------------------
  // Filter counter
  // ---------------------------------------------------------------
  // Counts how long the line disagrees with the recorded state; any
  // glitch that returns early restarts the count.
  always_ff @(posedge i_clk)
    if (!i_resetn || i_clear)
      cnt <= '0;
    else if (se0 == !o_conn)
      cnt <= '0; // see R22
    else if (cnt != FLT_W'(CONN_CYC))
      cnt <= cnt + FLT_W'(1);

  always_comb
  begin
    next_conn = o_conn;
    if (!o_conn && !se0 && cnt == FLT_W'(CONN_CYC - 1))
      next_conn = 1'b1; // see R09
    else if (o_conn && se0 && cnt == FLT_W'(DISC_CYC - 1))
      next_conn = 1'b0; // see R10
  end

  always_ff @(posedge i_clk)
    if (!i_resetn || i_clear)
      o_conn <= 1'b0;
    else
      o_conn <= next_conn;

  always_ff @(posedge i_clk)
    if (!i_resetn || i_clear)
      o_change <= 1'b0;
    else
      o_change <= next_conn != o_conn;

  // Speed follows the idle line at connect: D- high means low speed
  always_ff @(posedge i_clk)
    if (!i_resetn || i_clear)
      o_low_speed <= 1'b0;
    else if (next_conn && !o_conn)
      o_low_speed <= i_line.dm; // see R06 R07

endmodule : uhp_port_det

// *** core/uhp_hub_status.sv ***
// Hub port status logic: downstream detection, connect status,
// speed, addresses, hub interrupt, upstream status and forcing.
// Assumes an APB master on i_clk and raw USB pins from outside.
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module uhp_hub_status
  import uhp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [13:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Upstream port pins
  input wire uhp_pair_t i_up_line,
  input wire uhp_drive_t i_engine_drive,
  input wire logic i_engine_activity,
  output uhp_drive_t o_up_drive,
  output logic o_bus_reset,
  // Downstream port pins
  input wire uhp_pair_t [NPORT-1:0] i_dn_line,
  // Engine configuration and hub interrupt
  output logic [6:0] o_addr_hub,
  output logic [6:0] o_addr_fn,
  output logic o_ep_size,
  output logic o_ep_mode,
  output logic o_hub_irq
);

  // One upstream and four downstream ports; packet framing,
  // CRC, handshakes and EOF1 end-of-packet stay in the packet
  // engine, which feeds i_engine_drive. see R01 R02 R14

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  uhp_pair_t [NPORT:0] s1, s2, s3;
  uhp_pair_t [NPORT:0] stable;

  always_ff @(posedge i_clk)
    if (!i_resetn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= {i_up_line, i_dn_line};
      s2 <= s1;
      s3 <= s2;
    end

  // A change counts once stages two and three agree
  always_ff @(posedge i_clk)
    if (!i_resetn)
      stable <= '0;
    else
      for (int i = 0; i <= NPORT; i++)
      begin
        if (s2[i].dp == s3[i].dp)
          stable[i].dp <= s2[i].dp;
        if (s2[i].dm == s3[i].dm)
          stable[i].dm <= s2[i].dm;
      end

  // ---------------------------------------------------------------
  // Upstream bus reset detection
  // ---------------------------------------------------------------
  logic [BRST_W-1:0] brst_cnt;
  logic up_se0;
  logic bus_clr;

  assign up_se0 = !stable[NPORT].dp && !stable[NPORT].dm;

  always_ff @(posedge i_clk)
    if (!i_resetn || !up_se0)
      brst_cnt <= '0;
    else if (brst_cnt != BRST_W'(BRST_CYC))
      brst_cnt <= brst_cnt + BRST_W'(1); // see R20

  assign bus_clr = brst_cnt == BRST_W'(BRST_CYC - 1);

  always_ff @(posedge i_clk)
    if (!i_resetn)
      o_bus_reset <= 1'b0;
    else
      o_bus_reset <= up_se0 && brst_cnt >= BRST_W'(BRST_CYC - 1);

  // ---------------------------------------------------------------
  // Downstream detectors
  // ---------------------------------------------------------------
  logic [NPORT-1:0] conn, low_spd, change;

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    uhp_port_det u_det (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_clear(bus_clr),
      .i_line(stable[p]),
      .o_conn(conn[p]),
      .o_low_speed(low_spd[p]),
      .o_change(change[p])
    );
  end

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic wr_en;
  logic [11:0] idx;
  logic [7:0] up_ctl;
  logic [NPORT-1:0] connect;
  logic [NPORT-1:0] speed;
  logic irq_ack;
  uhp_linectl_t lctl;

  assign idx = uhp_index(i_paddr);
  assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
  assign lctl = uhp_linectl_t'(up_ctl[2:0]);

  // Connect status follows the detectors; writes are accepted but
  // the next detector change overwrites them.
  always_ff @(posedge i_clk)
    if (!i_resetn || bus_clr)
      connect <= CONNECT_RST[NPORT-1:0]; // see R12
    else if (|change)
      connect <= conn; // see R11
    else if (wr_en && idx == CONNECT_IDX)
      connect <= i_pwdata[NPORT-1:0];

  // Speed bit 1 means low speed; firmware rewrites it after the
  // hub interrupt. see R08
  always_ff @(posedge i_clk)
    if (!i_resetn || bus_clr)
      speed <= SPEED_RST[NPORT-1:0];
    else
      for (int i = 0; i < NPORT; i++)
        if (change[i] && conn[i])
          speed[i] <= low_spd[i]; // see R06 R07
        else if (wr_en && idx == SPEED_IDX)
          speed[i] <= i_pwdata[i];

  always_ff @(posedge i_clk)
    if (!i_resetn || bus_clr)
    begin
      o_addr_hub <= ADDR_RST;
      o_addr_fn <= ADDR_RST;
    end
    else if (wr_en && idx == ADDR_HUB_IDX)
      o_addr_hub <= i_pwdata[6:0]; // see R04
    else if (wr_en && idx == ADDR_FN_IDX)
      o_addr_fn <= i_pwdata[6:0]; // see R04

  // Status bits 5 and 4 track pins; activity is sticky, set wins
  always_ff @(posedge i_clk)
    if (!i_resetn)
      up_ctl <= UPSTREAM_RST; // see R15
    else
    begin
      up_ctl[DP_BIT] <= stable[NPORT].dp; // see R19
      up_ctl[DM_BIT] <= stable[NPORT].dm; // see R19
      if (wr_en && idx == UPSTREAM_IDX)
      begin
        up_ctl[7:6] <= i_pwdata[7:6];
        up_ctl[2:0] <= i_pwdata[2:0];
      end
      if (i_engine_activity)
        up_ctl[ACT_BIT] <= 1'b1; // see R18
      else if (wr_en && idx == UPSTREAM_IDX && !i_pwdata[ACT_BIT])
        up_ctl[ACT_BIT] <= 1'b0; // see R18
    end

  always_ff @(posedge i_clk)
    if (!i_resetn)
    begin
      o_ep_size <= 1'b0;
      o_ep_mode <= 1'b0;
    end
    else
    begin
      o_ep_size <= up_ctl[7];
      o_ep_mode <= up_ctl[6];
    end

  // ---------------------------------------------------------------
  // Upstream line forcing
  // ---------------------------------------------------------------
  // Firmware keeps the field at zero in normal use. see R16
  always_ff @(posedge i_clk)
    if (!i_resetn)
      o_up_drive <= '0;
    else
      case (lctl)
        LC_ENGINE: o_up_drive <= i_engine_drive; // see R17
        LC_J: o_up_drive <= '{1'b1, 1'b1, 1'b0, 1'b1};
        LC_K: o_up_drive <= '{1'b0, 1'b1, 1'b1, 1'b1};
        LC_SE0: o_up_drive <= '{1'b0, 1'b1, 1'b0, 1'b1};
        LC_LOW: o_up_drive <= '{1'b0, 1'b1, 1'b0, 1'b1};
        LC_DPZ_DMLOW: o_up_drive <= '{1'b0, 1'b0, 1'b0, 1'b1};
        LC_DPLOW_DMZ: o_up_drive <= '{1'b0, 1'b1, 1'b0, 1'b0};
        default: o_up_drive <= '0;
      endcase

  // ---------------------------------------------------------------
  // Hub interrupt
  // ---------------------------------------------------------------
  // Forced upstream suppresses connect events. Any write to the
  // acknowledge word clears; a change in the same cycle wins.
  assign irq_ack = wr_en && idx == IRQ_IDX;

  always_ff @(posedge i_clk)
    if (!i_resetn || bus_clr)
      o_hub_irq <= 1'b0;
    else if (|change && lctl == LC_ENGINE)
      o_hub_irq <= 1'b1; // see R06 R07 R10 R21
    else if (irq_ack)
      o_hub_irq <= 1'b0; // see R21

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  // One wait state: setup, access with pready low, then pready high
  always_ff @(posedge i_clk)
    if (!i_resetn)
      o_pready <= 1'b0;
    else
      o_pready <= i_psel && i_penable && !o_pready;

  always_ff @(posedge i_clk)
    if (!i_resetn)
    begin
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end
    else if (i_psel && i_penable && !o_pready)
    begin
      o_pslverr <= 1'b0;
      o_prdata <= '0;
      if (idx == UPSTREAM_IDX)
        o_prdata[7:0] <= up_ctl;
      else if (idx == CONNECT_IDX)
        o_prdata[7:0] <= {4'h0, connect}; // see R13
      else if (idx == SPEED_IDX)
        o_prdata[7:0] <= {4'h0, speed};
      else if (idx == ADDR_HUB_IDX)
        o_prdata[7:0] <= {1'b0, o_addr_hub};
      else if (idx == ADDR_FN_IDX)
        o_prdata[7:0] <= {1'b0, o_addr_fn};
      else if (idx == IRQ_IDX)
        o_prdata[7:0] <= {7'h00, o_hub_irq};
      else
        o_pslverr <= 1'b1;
    end
    else
      o_pslverr <= 1'b0;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_CONN_UPPER_ZERO: assert property (@(posedge i_clk) // see R13
    disable iff (!i_resetn)
    o_pready && idx == CONNECT_IDX && !i_pwrite |-> o_prdata[7:4] == 4'h0)
    else $error("connect status upper bits not zero");

  AST_BUSRST_CLEARS: assert property (@(posedge i_clk) // see R12
    disable iff (!i_resetn)
    bus_clr |=> connect == '0 && !o_hub_irq)
    else $error("bus reset did not clear status");

  AST_IRQ_ON_CHANGE: assert property (@(posedge i_clk) // see R21
    disable iff (!i_resetn)
    |change && lctl == LC_ENGINE && !bus_clr |=> o_hub_irq)
    else $error("hub interrupt not raised on change");

  AST_IRQ_HOLD: assert property (@(posedge i_clk) // see R21
    disable iff (!i_resetn)
    o_hub_irq && !irq_ack && !bus_clr |=> o_hub_irq)
    else $error("hub interrupt dropped without ack");

  AST_ACT_STICKY: assert property (@(posedge i_clk) // see R18
    disable iff (!i_resetn)
    i_engine_activity |=> up_ctl[ACT_BIT])
    else $error("bus activity not set");

  AST_ACT_WR1_KEEP: assert property (@(posedge i_clk) // see R18
    disable iff (!i_resetn)
    up_ctl[ACT_BIT] && wr_en && i_pwdata[ACT_BIT] |=> up_ctl[ACT_BIT])
    else $error("writing one cleared activity");

  AST_PIN_STATUS: assert property (@(posedge i_clk) // see R19
    disable iff (!i_resetn)
    ##1 up_ctl[DP_BIT] == $past(stable[NPORT].dp))
    else $error("upstream D+ status wrong");

  AST_SE0_FORCE: assert property (@(posedge i_clk) // see R17
    disable iff (!i_resetn)
    lctl == LC_SE0 |=> o_up_drive == uhp_drive_t'{1'b0, 1'b1, 1'b0, 1'b1})
    else $error("forced SE0 not driven");

  AST_BUSRST_TIME: assert property (@(posedge i_clk) // see R20
    disable iff (!i_resetn)
    o_bus_reset |-> brst_cnt >= BRST_W'(RST_MIN_US * CLK_MHZ - 1))
    else $error("bus reset too early");

  AST_CONN_MATCH: assert property (@(posedge i_clk) // see R11
    disable iff (!i_resetn)
    |change && !bus_clr |=> connect == $past(conn))
    else $error("connect status does not match");

  COV_CONNECT: cover property (@(posedge i_clk) |(change & conn));
  COV_DISCONNECT: cover property (@(posedge i_clk) |(change & ~conn));
  COV_FORCED_CHANGE: cover property (@(posedge i_clk)
    |change && lctl != LC_ENGINE);
  COV_BUSRST: cover property (@(posedge i_clk) bus_clr);
  COV_ACK: cover property (@(posedge i_clk) o_hub_irq && irq_ack);

endmodule : uhp_hub_status

// *** tb/uhp_usb_far.sv ***
// Far-side model: USB host on the upstream pair, devices downstream.
// Assumes the hub's drive request and the bench's attach commands.
`timescale 1ns/100ps
module uhp_usb_far
  import uhp_pkg::*;
(
  // Commands from the bench: 0 none, 1 full speed, 2 low speed
  input wire logic i_host_se0,
  input wire logic [NPORT-1:0][1:0] i_dev,
  // Hub side of the wires
  input wire uhp_drive_t i_up_drive,
  output uhp_pair_t o_up_line,
  output uhp_pair_t [NPORT-1:0] o_dn_line
);
  // -------------------------------------------------------------
  // Wire resolution
  // -------------------------------------------------------------
  // Released D+ rests on the hub pull-up unless the host drives SE0, released D- on the host
  // pull-down, so a released pair never shows a stale value
  always_comb
  begin
    o_up_line.dp = i_up_drive.dp_oe ? i_up_drive.dp_o : !i_host_se0;
    o_up_line.dm = i_up_drive.dm_oe ? i_up_drive.dm_o : 1'b0;
    for (int p = 0; p < NPORT; p++)
    begin
      // An empty port leaves both lines on the pull-downs
      o_dn_line[p].dp = (i_dev[p] == 2'h1);
      o_dn_line[p].dm = (i_dev[p] == 2'h2);
    end
  end
endmodule : uhp_usb_far

// *** tb/test_usb_hub_port_status_logic.sv ***
// Self-checking bench for the hub port status logic.
// Assumes the far-side model and an APB master made here.
`timescale 1ns/100ps
module test_usb_hub_port_status_logic;
  import uhp_pkg::*;
  logic i_clk, i_resetn, psel, penable, pwrite, host_se0, act;
  logic [13:0] paddr;
  logic [31:0] pwdata, o_prdata, rd;
  logic o_pready, o_pslverr, o_bus_reset, o_hub_irq, err;
  logic o_ep_size, o_ep_mode;
  logic [6:0] o_addr_hub, o_addr_fn;
  logic [NPORT-1:0][1:0] dev;
  uhp_pair_t up_line;
  uhp_pair_t [NPORT-1:0] dn_line;
  uhp_drive_t eng_drv, o_up_drive;
  int err_count, cmp_count, cyc;
  logic [3:0] exp_drv [8] = '{4'hb, 4'hd, 4'h7, 4'h5, 4'h5, 4'h1, 4'h4, 4'h0};
  logic [3:0] drv_mask [8] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h7, 4'hd, 4'h5};
  logic [1:0] exp_pin [8] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2};

  uhp_hub_status uhp_hub_status_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_up_line(up_line),
    .i_engine_drive(eng_drv), .i_engine_activity(act),
    .o_up_drive(o_up_drive), .o_bus_reset(o_bus_reset),
    .i_dn_line(dn_line), .o_addr_hub(o_addr_hub), .o_addr_fn(o_addr_fn),
    .o_ep_size(o_ep_size), .o_ep_mode(o_ep_mode), .o_hub_irq(o_hub_irq));
  uhp_usb_far uhp_usb_far_inst (.i_host_se0(host_se0), .i_dev(dev),
    .i_up_drive(o_up_drive), .o_up_line(up_line), .o_dn_line(dn_line));

  // -------------------------------------------------------------
  // Clock, timeout and shared tasks
  // -------------------------------------------------------------
  initial
  begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  // The whole run needs about 4000 cycles
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  // Holds the request until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [11:0] idx,
    input logic [7:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge i_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 20);
    chk("pready", 1, o_pready);
    rd = o_prdata;
    err = o_pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge i_clk);
  endtask : apb
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1, idx, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] idx,
    input logic [7:0] e);
    apb(0, idx, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask : rdc

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  // The bench plays firmware: setup answers, FIFOs and toggles stay
  // outside this block, which holds no logic for them.
  task automatic t_reset();
    rdc("upstream", UPSTREAM_IDX, 8'h00);
    rdc("connect", CONNECT_IDX, 8'h00);
    rdc("speed", SPEED_IDX, 8'h00);
    apb(0, 12'h7ff, 8'h00);
    chk("unmapped err", 1, err);
    host_se0 <= 0;
    $display("test reset done");
  endtask : t_reset
  task automatic t_upstream();
    wr(UPSTREAM_IDX, 8'hc8);
    rdc("activity kept", UPSTREAM_IDX, 8'he0);
    chk("ep size", 1, o_ep_size);
    chk("ep mode", 1, o_ep_mode);
    act <= 1;
    tick(1);
    act <= 0;
    rdc("activity set", UPSTREAM_IDX, 8'he8);
    wr(UPSTREAM_IDX, 8'hc8);
    rdc("activity one", UPSTREAM_IDX, 8'he8);
    wr(UPSTREAM_IDX, 8'hc0);
    rdc("activity clear", UPSTREAM_IDX, 8'he0);
    $display("test upstream done");
  endtask : t_upstream
  task automatic t_linectl();
    eng_drv <= 4'hb;
    for (int c = 0; c < 8; c++)
    begin
      wr(UPSTREAM_IDX, 8'(c));
      tick(8);
      chk("drive", exp_drv[c], o_up_drive & drv_mask[c]);
      rdc("pins", UPSTREAM_IDX, {2'b00, exp_pin[c], 1'b0, 3'(c)});
    end
    wr(UPSTREAM_IDX, 8'h00);
    eng_drv <= 4'h0;
    $display("test line control done");
  endtask : t_linectl
  task automatic t_attach();
    dev[1] <= 2'h1;
    tick(100);
    dev[1] <= 2'h0;
    tick(300);
    chk("glitch irq", 0, o_hub_irq);
    dev[0] <= 2'h1;
    tick(250);
    chk("early irq", 0, o_hub_irq);
    tick(55);
    chk("full irq", 1, o_hub_irq);
    rdc("connect", CONNECT_IDX, 8'h01);
    rdc("speed full", SPEED_IDX, 8'h00);
    wr(IRQ_IDX, 8'h01);
    chk("irq ack", 0, o_hub_irq);
    dev[2] <= 2'h2;
    tick(310);
    chk("low irq", 1, o_hub_irq);
    rdc("connect", CONNECT_IDX, 8'h05);
    rdc("speed low", SPEED_IDX, 8'h04);
    wr(SPEED_IDX, 8'h04);
    wr(IRQ_IDX, 8'h01);
    wr(CONNECT_IDX, 8'hf5);
    rdc("reserved", CONNECT_IDX, 8'h05);
    $display("test attach done");
  endtask : t_attach
  task automatic t_detach();
    dev[0] <= 2'h0;
    tick(199);
    chk("early drop", 0, o_hub_irq);
    tick(51);
    chk("drop irq", 1, o_hub_irq);
    rdc("connect", CONNECT_IDX, 8'h04);
    wr(IRQ_IDX, 8'h01);
    wr(UPSTREAM_IDX, 8'h01);
    dev[3] <= 2'h1;
    tick(270);
    chk("forced irq", 0, o_hub_irq);
    rdc("forced connect", CONNECT_IDX, 8'h0c);
    dev[3] <= 2'h0;
    wr(UPSTREAM_IDX, 8'h00);
    tick(220);
    chk("unforced drop irq", 1, o_hub_irq);
    wr(IRQ_IDX, 8'h01);
    $display("test detach done");
  endtask : t_detach
  task automatic t_busrst();
    wr(ADDR_HUB_IDX, 8'h15);
    wr(ADDR_FN_IDX, 8'h2a);
    chk("hub addr", 7'h15, o_addr_hub);
    chk("fn addr", 7'h2a, o_addr_fn);
    host_se0 <= 1;
    tick(1195);
    chk("bus reset early", 0, o_bus_reset);
    tick(410);
    chk("bus reset", 1, o_bus_reset);
    rdc("connect", CONNECT_IDX, 8'h00);
    chk("hub addr", 7'h00, o_addr_hub);
    chk("fn addr", 7'h00, o_addr_fn);
    rdc("speed clr", SPEED_IDX, 8'h00);
    host_se0 <= 0;
    tick(320);
    rdc("reconnect", CONNECT_IDX, 8'h04);
    chk("reconnect irq", 1, o_hub_irq);
    $display("test bus reset done");
  endtask : t_busrst

  initial
  begin
    {psel, penable, pwrite, act, cyc, err_count, cmp_count} = 0;
    paddr = 0;
    pwdata = 0;
    dev = 0;
    eng_drv = 4'h0;
    host_se0 = 1;
    i_resetn = 0;
    tick(2);
    i_resetn <= 1;
    t_reset();
    t_upstream();
    t_linectl();
    t_attach();
    t_detach();
    t_busrst();
    finish_test();
  end
endmodule : test_usb_hub_port_status_logic
